// ---- core/rpdc_map.svh ----
`ifndef RPDC_MAP_SVH
`define RPDC_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RPDC_ADDR_W        8
`define RPDC_CFG_BASE      8'h00
`define RPDC_CFG_STRIDE    8'h04
`define RPDC_SEL_STATUS    8'h10

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define RPDC_PRIO_BIT      24
`define RPDC_HOLD_N_BIT    22
`define RPDC_EN_N_BIT      21
`define RPDC_BYPASS_BIT    20
`define RPDC_RATIO_MSB     19
`define RPDC_RATIO_LSB     0
`define RPDC_CFG_RESET     32'h0050_0000
`define RPDC_CFG_MASK      32'h0177_ffff
`define RPDC_MIN_RATIO     20'h00002

`endif

// ---- core/rpdc_pkg.sv ----
package rpdc_pkg;

  // Configuration fields held per reference
  typedef struct packed {
    logic        rank;
    logic        hold_n;
    logic        enable_n;
    logic        divider_bypass;
    logic [19:0] divide_ratio;
  } rpdc_cfg_t;

  // Reference selection result
  typedef struct packed {
    logic       valid;
    logic [1:0] index;
  } rpdc_sel_t;

endpackage : rpdc_pkg

// ---- core/rpdc_ref_prescale.sv ----
`timescale 1ns/1ps
`include "rpdc_map.svh"


module rpdc_ref_prescale
  import rpdc_pkg::*;
#(
  parameter int NUM_REFS = 4
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [`RPDC_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [31:0]             rd_data,
  input  wire logic [NUM_REFS-1:0]     ref_in,
  input  wire logic [NUM_REFS-1:0]     ref_valid,
  output logic      [NUM_REFS-1:0]     ref_out,
  output rpdc_sel_t                    ref_sel
);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // Register file and read path
  rpdc_cfg_t             cfg_q [NUM_REFS];
  logic [31:0]           rd_data_q;
  logic [31:0]           rd_mux;
  logic [NUM_REFS-1:0]   cfg_hit;
  logic                  status_hit;

  // Synchroniser stages and divided outputs
  logic [NUM_REFS-1:0]   meta_q;
  logic [NUM_REFS-1:0]   sync_q;
  logic [NUM_REFS-1:0]   prev_q;
  logic [NUM_REFS-1:0]   out_q;

  // Selection state
  logic                  first_rank_seen;
  rpdc_sel_t             sel_q;
  rpdc_sel_t             sel_d;

  // --------------------------------------------------------------------------
  // Field packing
  // --------------------------------------------------------------------------
  // Pack a config into the register word, reserved bits zero
  function automatic logic [31:0] cfg_word(input rpdc_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`RPDC_PRIO_BIT]                   = c.rank;
    w[`RPDC_HOLD_N_BIT]                 = c.hold_n;
    w[`RPDC_EN_N_BIT]                   = c.enable_n;
    w[`RPDC_BYPASS_BIT]                 = c.divider_bypass;
    w[`RPDC_RATIO_MSB:`RPDC_RATIO_LSB]  = c.divide_ratio;
    return w & `RPDC_CFG_MASK;
  endfunction : cfg_word

  // Unpack a written word; reserved bits dropped
  function automatic rpdc_cfg_t word_cfg(input logic [31:0] w);
    rpdc_cfg_t c;
    c.rank           = w[`RPDC_PRIO_BIT];
    c.hold_n         = w[`RPDC_HOLD_N_BIT];
    c.enable_n       = w[`RPDC_EN_N_BIT];
    c.divider_bypass = w[`RPDC_BYPASS_BIT];
    c.divide_ratio   = w[`RPDC_RATIO_MSB:`RPDC_RATIO_LSB];
    return c;
  endfunction : word_cfg

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // One-hot match of the configuration words
  always_comb
  begin
    cfg_hit = '0;
    for (int i = 0; i < NUM_REFS; i++)
    begin
      cfg_hit[i] = (addr == 8'(`RPDC_CFG_BASE + i * `RPDC_CFG_STRIDE));
    end
  end

  // Selection status word, read only
  assign status_hit = (addr == `RPDC_SEL_STATUS);

  // --------------------------------------------------------------------------
  // Register write path
  // --------------------------------------------------------------------------
  // Register writes; struct layout matches word bits 22:0 of the reset value, rank resets from word bit 23
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_REFS; i++)
      begin
        cfg_q[i] <= rpdc_cfg_t'(24'(`RPDC_CFG_RESET));
      end
    end
    else
    begin
      for (int i = 0; i < NUM_REFS; i++)
      begin
        if (wr_en && cfg_hit[i])
        begin
          cfg_q[i] <= word_cfg(wr_data);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------------
  // Read decode; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_REFS; i++)
    begin
      if (cfg_hit[i])
      begin
        rd_mux = cfg_word(cfg_q[i]);
      end
    end
    if (status_hit)
    begin
      rd_mux = {29'h0000_0000, sel_q.valid, sel_q.index};
    end
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      rd_data_q <= rd_mux;
    end
    else
    begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Read data port
  // --------------------------------------------------------------------------
  // Registered read word, zero between reads
  assign rd_data = rd_data_q;

  // --------------------------------------------------------------------------
  // Reference synchronisers
  // --------------------------------------------------------------------------
  // Two flip-flops before any logic reads a reference pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= ref_in;
      sync_q <= meta_q;
    end
  end

  // Previous synchronised level for rising edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= '0;
    end
    else
    begin
      prev_q <= sync_q;
    end
  end

  // --------------------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++)
    begin : gen_div
      // Per-reference counter and shaping flop
      logic [19:0] cnt_q;
      logic [19:0] ratio;
      logic [19:0] cnt_nxt;
      logic [19:0] high_cnt;
      logic        rise;
      logic        div_q;

      // Ratios below the minimum act as the minimum
      assign ratio    = (cfg_q[g].divide_ratio < `RPDC_MIN_RATIO) ?
                        `RPDC_MIN_RATIO : cfg_q[g].divide_ratio;
      assign high_cnt = ratio - (ratio >> 1);
      assign rise     = sync_q[g] & ~prev_q[g];
      assign cnt_nxt  = (cnt_q >= ratio - 20'h00001) ? 20'h00000 : cnt_q + 20'h00001;

      // Count reference rising edges and shape the divided clock
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_q    <= 20'h00000;
          div_q    <= 1'b0;
        end
        else if (cfg_q[g].divider_bypass)
        begin
          cnt_q    <= 20'h00000;
          div_q    <= sync_q[g];
        end
        else if (!cfg_q[g].hold_n)
        begin
          cnt_q    <= 20'h00000;
          div_q    <= 1'b1;
        end
        else if (cfg_q[g].enable_n)
        begin
          cnt_q    <= 20'h00000;
          div_q    <= 1'b0;
        end
        else if (rise)
        begin
          cnt_q    <= cnt_nxt;
          div_q    <= (cnt_nxt < high_cnt);
        end
      end

      // Each divided clock leaves straight from its flip-flop
      assign out_q[g] = div_q;
    end
  endgenerate

  // Divided or bypassed references
  assign ref_out = out_q;

  // --------------------------------------------------------------------------
  // Reference selection
  // --------------------------------------------------------------------------
  // Rank zero wins whenever a qualified reference carries it
  always_comb
  begin
    first_rank_seen = 1'b0;
    for (int i = 0; i < NUM_REFS; i++)
    begin
      if (ref_valid[i] && !cfg_q[i].rank)
      begin
        first_rank_seen = 1'b1;
      end
    end
  end

  // Lowest qualified index within the winning rank
  always_comb
  begin
    sel_d = '0;
    for (int i = NUM_REFS - 1; i >= 0; i--)
    begin
      if (ref_valid[i] && (cfg_q[i].rank != first_rank_seen))
      begin
        sel_d.valid = 1'b1;
        sel_d.index = 2'(i);
      end
    end
  end

  // Registered selection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= '0;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // --------------------------------------------------------------------------
  // Selection output
  // --------------------------------------------------------------------------
  // Selection leaves from its register
  assign ref_sel = sel_q;

endmodule : rpdc_ref_prescale

// ---- testbench/rpdc_dpll_model.sv ----
`timescale 1ns/1ps
// Monitor flags and DPLL edge counter
module rpdc_dpll_model (
  input  wire logic [3:0] qual,
  input  wire logic       clk,
  input  wire logic [3:0] ref_out,
  output logic      [3:0] ref_valid,
  output int              rises [4]
);
  logic [3:0] prev_q;
  // Qualify refs, count rises of each divided ref
  always_ff @(posedge clk)
  begin
    ref_valid <= qual;
    prev_q <= ref_out;
    for (int i = 0; i < 4; i++)
      rises[i] <= rises[i] + int'(ref_out[i] & ~prev_q[i]);
  end
endmodule : rpdc_dpll_model

// ---- testbench/rpdc_ref_prescale_chk.sv ----
`timescale 1ns/1ps
module rpdc_ref_prescale_chk
  import rpdc_pkg::*;
#(parameter int NUM_REFS = 4) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [7:0]          addr,
  input wire logic                wr_en,
  input wire logic                rd_en,
  input wire logic [31:0]         rd_data,
  input wire logic [NUM_REFS-1:0] ref_valid,
  input wire rpdc_sel_t           ref_sel
);
  logic [NUM_REFS-1:0] v_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Flags one cycle back
  always_ff @(posedge clk) v_q <= ref_valid;
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0) else $error("stray data");
  chk_wr_quiet: assert property ($past(wr_en) |-> rd_data == 32'h0) else $error("data on write");
  chk_rsvd_zero: assert property (rd_data[31:25] == 7'h0 && !rd_data[23])
    else $error("reserved bit set");
  chk_unmapped_rd: assert property ($past(rd_en) && $past(addr) > 8'h10 |-> rd_data == 32'h0)
    else $error("unmapped read");
  chk_status_rd: assert property ($past(rd_en) && $past(addr) == 8'h10
    |-> rd_data == {29'h0, $past(ref_sel)}) else $error("status read");
  chk_sel_none: assert property ($past(ref_valid) == '0 |-> ref_sel == '0)
    else $error("select without flags");
  chk_sel_valid: assert property ($past(rst_n) && |v_q
    |-> ref_sel.valid && v_q[ref_sel.index]) else $error("unqualified select");
  chk_sel_steady: assert property ($past(rst_n, 2) && $stable(ref_valid)
    && !$past(wr_en) |=> $stable(ref_sel)) else $error("select moved");
  cover property ($past(rd_en) && $past(addr) == 8'h10 && rd_data != 32'h0);
  cover property (ref_sel.valid && ref_sel.index == 2'h3);
  cover property ($past(rd_en) && $past(addr) == 8'h14);
endmodule : rpdc_ref_prescale_chk
bind rpdc_ref_prescale rpdc_ref_prescale_chk #(.NUM_REFS(NUM_REFS)) i_chk (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .ref_valid(ref_valid), .ref_sel(ref_sel));

// ---- testbench/rpdc_ref_prescale_tb.sv ----
`timescale 1ns/1ps
module rpdc_ref_prescale_tb;
  import rpdc_pkg::*;
  logic        clk, rst_n, wr_en, rd_en;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  ref_in, ref_valid, ref_out, qual;
  rpdc_sel_t   ref_sel;
  int          rises [4];
  int          fails, samples_checked, cyc, seed;
  int          base [4];
  logic [31:0] cfg [4];
  logic [31:0] pat [5] = '{32'h0050_0000, 32'h0040_0004, 32'h0040_0002, 32'h0, 32'h0060_0004};
  int          cnt [5] = '{8, 2, 4, 0, 0};
  rpdc_ref_prescale #(.NUM_REFS(4)) i_rpdc_ref_prescale (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ref_in(ref_in),
    .ref_valid(ref_valid), .ref_out(ref_out), .ref_sel(ref_sel));
  rpdc_dpll_model i_rpdc_dpll_model (.qual(qual), .clk(clk), .ref_out(ref_out),
    .ref_valid(ref_valid), .rises(rises));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Reference period six cycles, inside the bypass limit; run ceiling
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) ref_in <= ~ref_in;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a < 8'h10) cfg[a[3:2]] = d & 32'h0177_ffff;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check("rd_data", rd_data, e);
  endtask : rd
  // Model of selection: priority then index
  function automatic logic [31:0] exp_sel();
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
        if (ref_valid[i] && cfg[i][24] == p) return {29'h0, 1'b1, 2'(i)};
    return 32'h0;
  endfunction : exp_sel
  task automatic stop_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    seed = 32'heb6b;
    {rst_n, wr_en, rd_en, addr, wr_data, ref_in, qual, fails, samples_checked} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0050_0000);
    for (int i = 0; i < 4; i++) cfg[i] = 32'h0050_0000;
    rd(8'h14, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, cfg[1]);
    // Random priorities and qualified sets
    for (int n = 0; n < 40; n++)
    begin
      wr(8'(4 * (n % 4)), 32'h0050_0000 | ($random(seed) & 32'h0100_0000));
      qual <= 4'($random(seed));
      repeat (3) @(posedge clk);
      #1 check("ref_sel", 32'(ref_sel), exp_sel());
      rd(8'h10, exp_sel());
    end
    // Ratios of at least two, bypass, hold, disable
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h08, pat[k]);
      repeat (12) @(posedge clk);
      #1 for (int i = 0; i < 4; i++) base[i] = rises[i];
      repeat (48) @(posedge clk);
      #1 for (int i = 0; i < 4; i++)
        check("rises", rises[i] - base[i], (i == 2) ? cnt[k] : 8);
      if (k > 2) check("ref_out", 32'(ref_out[2]), 32'(k == 3));
    end
    stop_test();
  end
endmodule : rpdc_ref_prescale_tb
